// ==== verilog/cpu_regs_defines.svh ====
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH
// ---------------------------------------------------------------
// Reset values and vectors
// ---------------------------------------------------------------
`define STACK_RESET 16'h00ff
`define STACK_LOW_RELOAD 8'hff
`define RESET_VEC_HI 16'hfffe
`define ONE_16 16'h0001
`define ZERO_BYTE 8'h00
`define STACKED_BYTES 3'd5
// ---------------------------------------------------------------
// Condition flag positions
// ---------------------------------------------------------------
`define FL_OVF 7
`define FL_ONE6 6
`define FL_ONE5 5
`define FL_HALF 4
`define FL_MASK 3
`define FL_NEG 2
`define FL_ZERO 1
`define FL_CARRY 0
`define FLAGS_ONES 8'h60
`define FLAGS_RESET 8'h68
// ---------------------------------------------------------------
// Register bus offsets and responses
// ---------------------------------------------------------------
`define OFS_ACCUM 8'h00
`define OFS_INDEX 8'h04
`define OFS_STACK 8'h08
`define OFS_PROG 8'h0c
`define OFS_FLAGS 8'h10
`define OFS_STATUS 8'h14
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ==== verilog/cpu_regs_pkg.sv ====
package cpu_regs_pkg;
  // Sequencer operation codes
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_FETCH = 4'h1, OP_JUMP = 4'h2, OP_PUSH = 4'h3,
    OP_PULL = 4'h4, OP_RELOAD = 4'h5, OP_ALU = 4'h6, OP_EA_STACK = 4'h7,
    OP_EA_INDEX = 4'h8, OP_UNMASK = 4'h9, OP_SLEEP = 4'ha, OP_LOAD = 4'hb
  } op_t;
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_ADC = 3'h1, ALU_SUB = 3'h2, ALU_AND = 3'h3,
    ALU_SHL = 3'h4, ALU_ROL = 3'h5, ALU_BTST = 3'h6, ALU_PASS = 3'h7
  } alu_t;
  typedef enum logic [2:0] {
    DST_ACCUM = 3'h0, DST_IDX_LO = 3'h1, DST_IDX_HI = 3'h2,
    DST_FLAGS = 3'h3, DST_PROG_LO = 3'h4, DST_PROG_HI = 3'h5
  } dst_t;
  typedef struct packed {
    op_t op;
    alu_t alu;
    dst_t dst;
    logic [7:0] data;
    logic [15:0] addr;
  } cmd_t;
  typedef enum logic [3:0] {
    ST_VEC_HI = 4'b0001, ST_VEC_LO = 4'b0010,
    ST_RUN = 4'b0100, ST_INT = 4'b1000
  } state_t;
endpackage

// ==== verilog/cpu_register_and_flags.sv ====
// Behaviour
// RL1: Any reset forces the stack pointer to 0x00ff.
// RL2: Stack low-byte reload sets low byte to all ones, keeps high.
// RL3: Push decrements, pull increments the stack pointer per byte.
// RL4: Stack-relative address is stack pointer plus 8 or 16 bit offset.
// RL5: Program counter steps by one for each fetched byte.
// RL6: Jumps, taken branches, interrupts load a target into the counter.
// RL7: Leaving reset, counter loads vector from 0xfffe high, 0xffff low.
// RL8: Accumulator is 8 bits, feeding and receiving ALU results.
// RL9: Index pair is 16 bits, high and low byte, addressing 64K.
// RL10: Flag bits 6 and 5 always read as one.
// RL11: Overflow flag tracks two's complement overflow.
// RL12: Half-carry set on carry from bit 3 into bit 4 on adds.
// RL13: Mask set blocks maskable interrupts; clearing re-enables them.
// RL14: Interrupt entry stacks registers, then sets mask, then vectors.
// RL15: Interrupt entry never stacks the upper index byte.
// RL16: Highest-priority pending request is serviced first.
// RL17: Interrupt return pulls registers including the mask from stack.
// RL18: Reset sets the mask; the unmask instruction clears it.
// RL19: Negative flag copies bit 7 of the result.
// RL20: Zero flag set for a zero result, cleared otherwise.
// RL21: Carry on add carry-out or borrow; bit tests, shifts update it.
// RL22: Wait or stop clears mask and stops the clock until woken.
// RL23: Writes to the two always-one flag bits are ignored.
`timescale 1ns/1ps
`include "cpu_regs_defines.svh"
module cpu_register_and_flags
  import cpu_regs_pkg::*;
#(
  parameter int NIRQ = 8,
  parameter int AW = 8
)(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire cmd_t cmd_i,
  input wire logic insn_end_i,
  input wire logic [7:0] mem_data_i,
  input wire logic [NIRQ-1:0] irq_req_i,
  input wire logic [15:0] int_vec_i,
  output logic [7:0] accumulator_o,
  output logic [15:0] index_pair_o,
  output logic [15:0] stack_pointer_o,
  output logic [15:0] program_counter_o,
  output logic [7:0] condition_flags_o,
  output logic [15:0] ea_o,
  output logic vec_fetch_o,
  output logic [15:0] vec_addr_o,
  output logic irq_grant_o,
  output logic [$clog2(NIRQ)-1:0] irq_sel_o,
  output logic clk_stop_o,
  output logic running_o,
  input wire logic [AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  localparam int IW = $clog2(NIRQ);

  // Parameter sanity
  initial begin
    if (NIRQ < 2 || AW < 8)
      $error("NIRQ must be at least 2 and AW at least 8");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_t state, next_state;
  logic [7:0] accum, next_accum;
  logic [15:0] index, next_index;
  logic [15:0] stack, next_stack;
  logic [15:0] prog, next_prog;
  logic [7:0] flags, next_flags;
  logic [15:0] ea, next_ea;
  logic [15:0] vaddr, next_vaddr;
  logic [2:0] pushes, next_pushes;
  logic grant, next_grant;
  logic [IW-1:0] sel, next_sel;
  logic stop, next_stop;

  // ---------------------------------------------------------------
  // Register bus slave
  // ---------------------------------------------------------------
  logic aw_full, w_full, bvalid, arready, rvalid;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data, rdata;
  logic [3:0] wr_strb;
  logic [1:0] bresp, rresp;
  wire aw_take = s_axi_awvalid_i & ~aw_full;
  wire w_take = s_axi_wvalid_i & ~w_full;
  wire do_wr = aw_full & w_full & ~bvalid;
  wire ar_take = s_axi_arvalid_i & arready;
  wire wr_mapped = (wr_addr == `OFS_ACCUM) | (wr_addr == `OFS_INDEX) |
                   (wr_addr == `OFS_STACK) | (wr_addr == `OFS_PROG) |
                   (wr_addr == `OFS_FLAGS) | (wr_addr == `OFS_STATUS);
  // Bus writes only land between sequencer operations
  wire bus_apply = do_wr & (state == ST_RUN) & (cmd_i.op == OP_NOP);

  // Read decode
  wire [31:0] status_word = {19'h00000, stop, (|irq_req_i),
                             pushes, 4'h0, state};
  wire [31:0] rd_word =
    (s_axi_araddr_i == `OFS_ACCUM) ? {24'h000000, accum} :
    (s_axi_araddr_i == `OFS_INDEX) ? {16'h0000, index} :
    (s_axi_araddr_i == `OFS_STACK) ? {16'h0000, stack} :
    (s_axi_araddr_i == `OFS_PROG) ? {16'h0000, prog} :
    (s_axi_araddr_i == `OFS_FLAGS) ? {24'h000000, flags} :
    (s_axi_araddr_i == `OFS_STATUS) ? status_word : 32'h00000000;
  wire rd_mapped = (s_axi_araddr_i == `OFS_ACCUM) |
                   (s_axi_araddr_i == `OFS_INDEX) |
                   (s_axi_araddr_i == `OFS_STACK) |
                   (s_axi_araddr_i == `OFS_PROG) |
                   (s_axi_araddr_i == `OFS_FLAGS) |
                   (s_axi_araddr_i == `OFS_STATUS);

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Bus channel flops; awready and wready stay low while a word waits
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full <= 1'b1;
        wr_addr <= s_axi_awaddr_i;
      end
      else if (do_wr)
        aw_full <= 1'b0;
      if (w_take)
      begin
        w_full <= 1'b1;
        wr_data <= s_axi_wdata_i;
        wr_strb <= s_axi_wstrb_i;
      end
      else if (do_wr)
        w_full <= 1'b0;
      if (do_wr)
      begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        bvalid <= 1'b0;
      if (ar_take)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid & s_axi_rready_i)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt priority: lowest index wins
  // ---------------------------------------------------------------
  logic [NIRQ-1:0] above;
  logic [NIRQ-1:0] first;
  logic [IW-1:0] first_idx;
  assign above[0] = 1'b0;
  genvar g;
  for (g = 0; g < NIRQ; g++)
  begin : g_prio
    if (g > 0)
    begin : g_chain
      assign above[g] = above[g-1] | irq_req_i[g-1];
    end
    assign first[g] = irq_req_i[g] & ~above[g]; // RL16
  end

  // One-hot to index
  always_comb
  begin
    first_idx = '0;
    for (int i = 0; i < NIRQ; i++)
      if (first[i])
        first_idx = first_idx | i[IW-1:0];
  end

  // Masked requests never reach the grant
  wire take_irq = insn_end_i & ~flags[`FL_MASK] & (|irq_req_i) & ~stop; // RL13

  // ---------------------------------------------------------------
  // ALU and flag results
  // ---------------------------------------------------------------
  logic cin;
  logic [8:0] sum9, dif9;
  logic [4:0] half5;
  logic [7:0] res;
  logic c_new, v_new, h_new, upd_acc;
  always_comb
  begin
    cin = (cmd_i.alu == ALU_ADC) ? flags[`FL_CARRY] : 1'b0;
    sum9 = {1'b0, accum} + {1'b0, cmd_i.data} + {8'h00, cin};
    half5 = {1'b0, accum[3:0]} + {1'b0, cmd_i.data[3:0]} + {4'h0, cin};
    dif9 = {1'b0, accum} - {1'b0, cmd_i.data};
    res = accum;
    c_new = flags[`FL_CARRY];
    v_new = flags[`FL_OVF];
    h_new = flags[`FL_HALF];
    upd_acc = 1'b1;
    case (cmd_i.alu)
      ALU_ADD, ALU_ADC:
      begin
        res = sum9[7:0];
        c_new = sum9[8]; // RL21
        h_new = half5[4]; // RL12
        v_new = (accum[7] == cmd_i.data[7]) & (res[7] != accum[7]); // RL11
      end
      ALU_SUB:
      begin
        res = dif9[7:0];
        c_new = dif9[8]; // RL21
        v_new = (accum[7] != cmd_i.data[7]) & (res[7] != accum[7]); // RL11
      end
      ALU_AND:
      begin
        res = accum & cmd_i.data;
        v_new = 1'b0;
      end
      ALU_SHL, ALU_ROL:
      begin
        res = {accum[6:0], (cmd_i.alu == ALU_ROL) & flags[`FL_CARRY]};
        c_new = accum[7]; // RL21
        v_new = res[7] ^ accum[7];
      end
      ALU_BTST:
      begin
        c_new = cmd_i.data[0]; // RL21
        upd_acc = 1'b0;
      end
      default:
      begin
        res = cmd_i.data;
        v_new = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Register next values
  // ---------------------------------------------------------------
  wire pull_load = (cmd_i.op == OP_PULL) | (cmd_i.op == OP_LOAD);
  always_comb
  begin
    next_state = state;
    next_accum = accum;
    next_index = index;
    next_stack = stack;
    next_prog = prog;
    next_flags = flags;
    next_ea = ea;
    next_vaddr = vaddr;
    next_pushes = pushes;
    next_grant = 1'b0;
    next_sel = sel;
    next_stop = stop & ~(|irq_req_i); // RL22
    case (state)
      ST_VEC_HI:
      begin
        next_prog[15:8] = mem_data_i; // RL7
        next_vaddr = vaddr + `ONE_16;
        next_state = ST_VEC_LO;
      end
      ST_VEC_LO:
      begin
        next_prog[7:0] = mem_data_i; // RL7
        next_state = ST_RUN;
      end
      ST_INT:
        // Five bytes: counter, index low, accumulator, flags; no high index
        if (cmd_i.op == OP_PUSH)
        begin
          next_stack = stack - `ONE_16; // RL3 RL15
          next_pushes = pushes + 3'd1;
          if (pushes == `STACKED_BYTES - 3'd1)
          begin
            next_flags[`FL_MASK] = 1'b1; // RL14
            next_vaddr = int_vec_i; // RL6
            next_state = ST_VEC_HI;
          end
        end
      ST_RUN:
      begin
        case (cmd_i.op)
          OP_FETCH: next_prog = prog + `ONE_16; // RL5
          OP_JUMP: next_prog = cmd_i.addr; // RL6
          OP_PUSH: next_stack = stack - `ONE_16; // RL3
          OP_PULL: next_stack = stack + `ONE_16; // RL3
          OP_RELOAD: next_stack[7:0] = `STACK_LOW_RELOAD; // RL2
          OP_EA_STACK: next_ea = stack + cmd_i.addr; // RL4
          OP_EA_INDEX: next_ea = index + cmd_i.addr; // RL9
          OP_UNMASK: next_flags[`FL_MASK] = 1'b0; // RL18
          OP_SLEEP:
          begin
            next_flags[`FL_MASK] = 1'b0; // RL22
            next_stop = 1'b1;
          end
          OP_ALU:
          begin
            if (upd_acc)
            begin
              next_accum = res; // RL8
              next_flags[`FL_NEG] = res[7]; // RL19
              next_flags[`FL_ZERO] = (res == `ZERO_BYTE); // RL20
            end
            next_flags[`FL_CARRY] = c_new;
            next_flags[`FL_OVF] = v_new;
            next_flags[`FL_HALF] = h_new;
          end
          OP_NOP:
            if (bus_apply)
              case (wr_addr)
                `OFS_ACCUM:
                  if (wr_strb[0])
                    next_accum = wr_data[7:0];
                `OFS_INDEX: next_index = merge16(index, wr_data, wr_strb);
                `OFS_STACK: next_stack = merge16(stack, wr_data, wr_strb);
                `OFS_PROG: next_prog = merge16(prog, wr_data, wr_strb);
                `OFS_FLAGS:
                  if (wr_strb[0])
                    next_flags = wr_data[7:0] | `FLAGS_ONES; // RL23
                default: next_flags = flags;
              endcase
          default: next_flags = flags;
        endcase
        // Pulled or loaded bytes; flags restore keeps the fixed ones
        if (pull_load)
          case (cmd_i.dst)
            DST_ACCUM: next_accum = cmd_i.data;
            DST_IDX_LO: next_index[7:0] = cmd_i.data;
            DST_IDX_HI: next_index[15:8] = cmd_i.data;
            DST_FLAGS: next_flags = cmd_i.data | `FLAGS_ONES; // RL17 RL23
            DST_PROG_LO: next_prog[7:0] = cmd_i.data;
            default: next_prog[15:8] = cmd_i.data;
          endcase
        if (take_irq)
        begin
          next_grant = 1'b1;
          next_sel = first_idx; // RL16
          next_pushes = 3'd0;
          next_state = ST_INT;
        end
      end
      default: next_state = ST_VEC_HI;
    endcase
  end

  // Vector fetch strobe from its own flop, never a gate of state bits
  logic fetching;
  wire next_fetch = (next_state == ST_VEC_HI) | (next_state == ST_VEC_LO);

  // Core flops; reset also arms the reset vector fetch
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state <= ST_VEC_HI;
      accum <= `ZERO_BYTE;
      index <= 16'h0000;
      stack <= `STACK_RESET; // RL1
      prog <= 16'h0000;
      flags <= `FLAGS_RESET; // RL18 RL10
      ea <= 16'h0000;
      vaddr <= `RESET_VEC_HI; // RL7
      pushes <= 3'd0;
      grant <= 1'b0;
      sel <= '0;
      stop <= 1'b0;
      fetching <= 1'b1;
    end
    else
    begin
      state <= next_state;
      accum <= next_accum;
      index <= next_index;
      stack <= next_stack;
      prog <= next_prog;
      flags <= next_flags;
      ea <= next_ea;
      vaddr <= next_vaddr;
      pushes <= next_pushes;
      grant <= next_grant;
      sel <= next_sel;
      stop <= next_stop;
      fetching <= next_fetch;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flops
  // ---------------------------------------------------------------
  assign accumulator_o = accum;
  assign index_pair_o = index;
  assign stack_pointer_o = stack;
  assign program_counter_o = prog;
  assign condition_flags_o = flags;
  assign ea_o = ea;
  assign vec_fetch_o = fetching;
  assign vec_addr_o = vaddr;
  assign irq_grant_o = grant;
  assign irq_sel_o = sel;
  assign clk_stop_o = stop;
  assign running_o = state[2];
  assign s_axi_awready_o = ~aw_full;
  assign s_axi_wready_o = ~w_full;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = arready;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  wire run_op = (state == ST_RUN);
  AST_PUSH_STEP: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) (run_op && cmd_i.op == OP_PUSH && !take_irq)
    |=> stack == $past(stack) - `ONE_16) else $error("push step"); // RL3
  AST_RELOAD: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) (run_op && cmd_i.op == OP_RELOAD)
    |=> stack[7:0] == `STACK_LOW_RELOAD &&
        $stable(stack[15:8])) else $error("reload"); // RL2
  AST_FETCH: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) (run_op && cmd_i.op == OP_FETCH)
    |=> prog == $past(prog) + `ONE_16) else $error("fetch step"); // RL5
  AST_JUMP: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) (run_op && cmd_i.op == OP_JUMP)
    |=> prog == $past(cmd_i.addr)) else $error("jump load"); // RL6
  AST_VECTOR: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) (state == ST_VEC_HI) ##1 (state == ST_VEC_LO)
    |=> prog == {$past(mem_data_i, 2), $past(mem_data_i)} && running_o)
    else $error("vector load"); // RL7
  AST_ONES: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) flags[`FL_ONE6] && flags[`FL_ONE5])
    else $error("fixed flag bits"); // RL10
  AST_MASKED: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) $rose(grant) |-> !$past(flags[`FL_MASK]))
    else $error("masked grant"); // RL13
  AST_ENTRY: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) (state == ST_INT) ##1 (state == ST_VEC_HI)
    |-> flags[`FL_MASK] && $past(pushes) == `STACKED_BYTES - 3'd1)
    else $error("entry order"); // RL14
  AST_HALF: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (run_op && cmd_i.op == OP_ALU && cmd_i.alu == ALU_ADD)
    |=> flags[`FL_HALF] == ({1'b0, $past(accum[3:0])} +
        $past(cmd_i.data[3:0]) > 5'h0f)) else $error("half carry"); // RL12
  AST_ZERO: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (run_op && cmd_i.op == OP_ALU && cmd_i.alu != ALU_BTST)
    |=> flags[`FL_ZERO] == (accum == `ZERO_BYTE) &&
        flags[`FL_NEG] == accum[7]) else $error("zero neg"); // RL20 RL19
  AST_SLEEP: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i) (run_op && cmd_i.op == OP_SLEEP && !take_irq)
    |=> !flags[`FL_MASK] && stop) else $error("sleep"); // RL22
endmodule // cpu_register_and_flags

// ==== tb/vector_memory.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Memory model answering vector byte reads
// ---------------------------------------------------------------
module vector_memory #(
  parameter logic [15:0] VEC_RST = 16'hc123,
  parameter logic [15:0] VEC_INT = 16'h4e56,
  parameter logic [15:0] INT_BASE = 16'hfff4
)(
  input wire logic sys_clk_i,
  input wire logic vec_fetch_i,
  input wire logic [15:0] vec_addr_i,
  output logic [7:0] mem_data_o
);
  logic [7:0] last;
  logic [7:0] byte_at;
  // High byte at the even address, low byte next to it
  assign byte_at = (vec_addr_i == 16'hfffe) ? VEC_RST[15:8] :
                   (vec_addr_i == 16'hffff) ? VEC_RST[7:0] :
                   (vec_addr_i == INT_BASE) ? VEC_INT[15:8] :
                   (vec_addr_i == INT_BASE + 16'h0001) ? VEC_INT[7:0] :
                   8'h00;
  // Bus not read: show the inverse so a stale byte never matches
  assign mem_data_o = vec_fetch_i ? byte_at : ~last;
  always_ff @(posedge sys_clk_i)
  begin
    if (vec_fetch_i) last <= byte_at;
  end
endmodule // vector_memory

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import cpu_regs_pkg::*;
;
  localparam logic [15:0] VR = 16'hc123;
  localparam logic [15:0] VI = 16'h4e56;
  localparam logic [15:0] IB = 16'hfff4;
  typedef struct packed {
    alu_t a;
    logic [7:0] x, m, r, f, c;
  } row_t;
  // Operand, result, flags, flag bits that matter
  row_t rows[9] = '{
    '{ALU_ADD, 8'h7f, 8'h01, 8'h80, 8'hfc, 8'hff},
    '{ALU_ADD, 8'hff, 8'h01, 8'h00, 8'h7b, 8'hff},
    '{ALU_ADC, 8'h10, 8'h20, 8'h31, 8'h68, 8'hff},
    '{ALU_SUB, 8'h00, 8'h01, 8'hff, 8'h6d, 8'hef},
    '{ALU_AND, 8'hf0, 8'h0f, 8'h00, 8'h6b, 8'hff},
    '{ALU_SHL, 8'hc1, 8'h00, 8'h82, 8'h6d, 8'hff},
    '{ALU_ROL, 8'h41, 8'h00, 8'h83, 8'hec, 8'hff},
    '{ALU_BTST, 8'h55, 8'h01, 8'h55, 8'hed, 8'hff},
    '{ALU_ADD, 8'h08, 8'h08, 8'h10, 8'h78, 8'hff}};
  logic clk, rst_n, iend, fetch, grant, stop, run;
  logic awv, awr, wv, wr, bv, bready, arv, arr, rv, rready;
  cmd_t cmd;
  logic [7:0] mdata, acc, fl, awaddr, araddr;
  logic [7:0] irq;
  logic [15:0] idx, sp, pc, ea, vaddr;
  logic [2:0] sel;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  int failures, check_count, i;
  cpu_register_and_flags i_dut (.sys_clk_i(clk), .reset_n_i(rst_n),
    .cmd_i(cmd), .insn_end_i(iend), .mem_data_i(mdata), .irq_req_i(irq),
    .int_vec_i(IB), .accumulator_o(acc), .index_pair_o(idx),
    .stack_pointer_o(sp), .program_counter_o(pc), .condition_flags_o(fl),
    .ea_o(ea), .vec_fetch_o(fetch), .vec_addr_o(vaddr),
    .irq_grant_o(grant), .irq_sel_o(sel), .clk_stop_o(stop),
    .running_o(run), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready));
  vector_memory #(.VEC_RST(VR), .VEC_INT(VI), .INT_BASE(IB)) i_mem (
    .sys_clk_i(clk), .vec_fetch_i(fetch), .vec_addr_i(vaddr),
    .mem_data_o(mdata));
  // ---------------------------------------------------------------
  // Clock, checks and ending
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (e !== g)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, far beyond the roughly 120 cycles of the run
  initial
  begin
    #20000;
    failures++;
    close_out;
  end
  // ---------------------------------------------------------------
  // Drivers: one sequencer op, then idle so bus writes may land
  // ---------------------------------------------------------------
  task run_op(input op_t o, alu_t a, dst_t d, logic [7:0] x,
              logic [15:0] ad);
    @(posedge clk);
    cmd <= '{op: o, alu: a, dst: d, data: x, addr: ad};
    @(posedge clk);
    cmd <= '{OP_NOP, ALU_PASS, DST_ACCUM, 8'h00, 16'h0000};
    #1;
  endtask
  task axw(input logic [7:0] a, logic [31:0] d, logic [3:0] s,
           logic [1:0] er);
    logic bd;
    @(posedge clk);
    awaddr <= a;
    awv <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wv <= 1'b1;
    bready <= 1'b1;
    bd = 1'b0;
    while (!bd)
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bready && bv) bd = 1'b1;
      if (bd) chk("bresp", er, bresp);
    end
    bready <= 1'b0;
    #1;
  endtask
  task axr(input logic [7:0] a);
    logic rd_done;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    rd_done = 1'b0;
    while (!rd_done)
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rready && rv) rd_done = 1'b1;
      rd = rdata;
      rr = rresp;
    end
    rready <= 1'b0;
  endtask
  task wait_run;
    for (i = 0; i < 10 && run !== 1'b1; i++) @(posedge clk);
    #1;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {rst_n, iend, irq, awv, wv, bready, arv, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    cmd = '{OP_NOP, ALU_PASS, DST_ACCUM, 8'h00, 16'h0000};
    @(posedge clk);
    #1;
    chk("stack", 16'h00ff, sp);
    chk("flags", 8'h68, fl);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_run;
    chk("pc", VR, pc);
    foreach (rows[k])
    begin
      run_op(OP_LOAD, ALU_PASS, DST_ACCUM, rows[k].x, 16'h0000);
      run_op(OP_ALU, rows[k].a, DST_ACCUM, rows[k].m, 16'h0000);
      chk("acc", rows[k].r, acc);
      chk("flags", rows[k].f & rows[k].c, fl & rows[k].c);
    end
    run_op(OP_LOAD, ALU_PASS, DST_FLAGS, 8'h08, 16'h0000);
    chk("flags", 8'h68, fl);
    run_op(OP_UNMASK, ALU_PASS, DST_ACCUM, 8'h00, 16'h0000);
    chk("mask", 1'b0, fl[3]);
    run_op(OP_LOAD, ALU_PASS, DST_FLAGS, 8'h08, 16'h0000);
    run_op(OP_SLEEP, ALU_PASS, DST_ACCUM, 8'h00, 16'h0000);
    chk("stop", 2'b10, {stop, fl[3]});
    @(posedge clk);
    irq <= 8'h24;
    repeat (2) @(posedge clk);
    #1;
    chk("stop", 1'b0, stop);
    // Two pending sources: the lower index must win
    @(posedge clk);
    iend <= 1'b1;
    for (i = 0; i < 8 && grant !== 1'b1; i++) @(posedge clk) #1;
    chk("sel", 3'd2, sel);
    @(posedge clk);
    iend <= 1'b0;
    repeat (4) run_op(OP_PUSH, ALU_PASS, DST_ACCUM, 8'h00, 16'h0000);
    chk("mask", 1'b0, fl[3]);
    run_op(OP_PUSH, ALU_PASS, DST_ACCUM, 8'h00, 16'h0000);
    chk("mask", 1'b1, fl[3]);
    chk("stack", 16'h00fa, sp);
    @(posedge clk);
    irq <= 8'h00;
    wait_run;
    chk("pc", VI, pc);
    run_op(OP_PULL, ALU_PASS, DST_FLAGS, 8'h00, 16'h0000);
    chk("flags", 8'h60, fl);
    chk("stack", 16'h00fb, sp);
    run_op(OP_FETCH, ALU_PASS, DST_ACCUM, 8'h00, 16'h0000);
    chk("pc", VI + 16'h0001, pc);
    run_op(OP_JUMP, ALU_PASS, DST_ACCUM, 8'h00, 16'hbeef);
    chk("pc", 16'hbeef, pc);
    axw(8'h08, 32'h0000_1234, 4'h3, 2'b00);
    run_op(OP_RELOAD, ALU_PASS, DST_ACCUM, 8'h00, 16'h0000);
    chk("stack", 16'h12ff, sp);
    run_op(OP_PUSH, ALU_PASS, DST_ACCUM, 8'h00, 16'h0000);
    run_op(OP_EA_STACK, ALU_PASS, DST_ACCUM, 8'h00, 16'h0010);
    chk("ea", 16'h130e, ea);
    axw(8'h04, 32'hffff_a55a, 4'h3, 2'b00);
    run_op(OP_EA_INDEX, ALU_PASS, DST_ACCUM, 8'h00, 16'h0100);
    chk("ea", 16'ha65a, ea);
    run_op(OP_PULL, ALU_PASS, DST_IDX_HI, 8'h3c, 16'h0000);
    chk("index", 16'h3c5a, idx);
    axr(8'h00);
    chk("rdata", 8'h10, rd[7:0]);
    axr(8'h40);
    chk("rresp", 2'b10, rr);
    axw(8'h44, 32'h0, 4'hf, 2'b10);
    axw(8'h14, 32'h0, 4'hf, 2'b00);
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("stack", 16'h00ff, sp);
    chk("mask", 1'b1, fl[3]);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_run;
    chk("pc", VR, pc);
    close_out;
  end
endmodule // testbench
